// ### core/sbsr_pkg.sv
// Package for the status byte and service request block.
// Assumes a single instrument clock; shared by the top and the self-test unit.
`default_nettype none
package sbsr_pkg;
  // ==========================================================================
  // Status byte layout
  localparam int          STB_INPUT_BUF_BIT = 0;
  localparam int          STB_MSG_AVAIL_BIT = 4;
  localparam int          STB_EVENT_SUM_BIT = 5;
  localparam int          STB_MSS_BIT       = 6;
  localparam int          STB_BIT1_POS      = 1;
  localparam int          STB_BIT2_POS      = 2;
  localparam int          STB_BIT3_POS      = 3;
  localparam int          STB_BIT7_POS      = 7;
  localparam logic [7:0]  SRE_WRITE_MASK    = 8'hBF;
  localparam logic [7:0]  SRE_RESET         = 8'h00;
  localparam logic [7:0]  ESE_RESET         = 8'h00;
  localparam logic [7:0]  BYTE_ZERO         = 8'h00;
  // ==========================================================================
  // Self-test
  localparam int          NUM_CHANNELS      = 2;
  localparam logic [15:0] TST_PASS          = 16'h0000;
  localparam int          TST_CH_FAIL_BIT0  = 8;
  localparam int          TST_TRIG_FAIL_BIT = 12;
  localparam int          TST_TB_FAIL_BIT   = 13;
  localparam int          TST_STEP_CYCLES   = 16;
  localparam logic [3:0]  TST_STEP_LAST     = 4'(TST_STEP_CYCLES - 1);
  // ==========================================================================
  // Command codes
  typedef enum logic [2:0] {
    SBSR_CMD_NONE   = 3'h0,
    SBSR_CMD_SRE_WR = 3'h1,
    SBSR_CMD_SRE_RD = 3'h2,
    SBSR_CMD_STB_RD = 3'h3,
    SBSR_CMD_TST    = 3'h4,
    SBSR_CMD_WAI    = 3'h5,
    SBSR_CMD_CLS    = 3'h6,
    SBSR_CMD_ESE_WR = 3'h7
  } sbsr_cmd_t;

  typedef enum logic [3:0] {
    SBSR_ST_IDLE  = 4'b0001,
    SBSR_ST_CHAN  = 4'b0010,
    SBSR_ST_TRIG  = 4'b0100,
    SBSR_ST_DONE  = 4'b1000
  } sbsr_tst_t;

  function automatic logic sbsr_any_enabled(input logic [7:0] stb, input logic [7:0] en);
    return |(stb & en & SRE_WRITE_MASK);
  endfunction : sbsr_any_enabled
endpackage : sbsr_pkg
`default_nettype wire

// ### core/sbsr_selftest.sv
// Self-test sequencer: walks each output channel, then trigger and time base.
// Assumes failure flags from the hardware checkers are stable while sampled.
`default_nettype none
module sbsr_selftest
  import sbsr_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    start,
  input  wire logic [NUM_CHANNELS-1:0] chan_fail,
  input  wire logic                    trig_fail,
  input  wire logic                    tbase_fail,
  output var  logic                    busy,
  output var  logic                    done,
  output var  logic [15:0]             result
);
  import sbsr_pkg::*;
  sbsr_tst_t   state_ff, nxt_state;
  logic [3:0]  cnt_ff, nxt_cnt;
  logic [0:0]  ch_ff, nxt_ch;
  logic [15:0] res_ff, nxt_res;

  // ==========================================================================
  // Sequencer
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    nxt_ch    = ch_ff;
    nxt_res   = res_ff;
    unique case (state_ff)
      SBSR_ST_IDLE: begin
        if (start) begin
          nxt_state = SBSR_ST_CHAN;
          nxt_cnt   = '0;
          nxt_ch    = '0;
          nxt_res   = TST_PASS;
        end
      end
      SBSR_ST_CHAN: begin
        // Every channel gets its full step before the result is reported.
        nxt_cnt = cnt_ff + 4'h1;
        if (cnt_ff == TST_STEP_LAST) begin
          // Each failure lands on its own bit.
          if (chan_fail[ch_ff]) nxt_res[TST_CH_FAIL_BIT0 + int'(ch_ff)] = 1'b1;
          nxt_cnt = '0;
          if (int'(ch_ff) == NUM_CHANNELS - 1) nxt_state = SBSR_ST_TRIG;
          else nxt_ch = ch_ff + 1'b1;
        end
      end
      SBSR_ST_TRIG: begin
        nxt_res[TST_TRIG_FAIL_BIT] = trig_fail;
        nxt_res[TST_TB_FAIL_BIT]   = tbase_fail;
        nxt_state = SBSR_ST_DONE;
      end
      SBSR_ST_DONE: begin
        nxt_state = SBSR_ST_IDLE;
      end
      default: nxt_state = SBSR_ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= SBSR_ST_IDLE;
      cnt_ff   <= '0;
      ch_ff    <= '0;
      res_ff   <= TST_PASS;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      ch_ff    <= nxt_ch;
      res_ff   <= nxt_res;
    end
  end

  assign busy   = (state_ff != SBSR_ST_IDLE);
  assign done   = (state_ff == SBSR_ST_DONE);
  assign result = res_ff;
endmodule : sbsr_selftest
`default_nettype wire

// ### core/sbsr_top.sv
// Status byte, service request enable and self-test reporting of the remote interface.
// Assumes the command parser issues one command at a time and waits for CMD_READY.
`default_nettype none
module sbsr_top
  import sbsr_pkg::*;
(
  input  wire logic                              CLK,
  input  wire logic                              RESETN,
  input  wire logic                              CMD_VALID,
  input  wire sbsr_pkg::sbsr_cmd_t               CMD_CODE,
  input  wire logic [7:0]                        CMD_DATA,
  input  wire logic                              INPUT_BUFFER_SUMMARY,
  input  wire logic                              MSG_AVAILABLE,
  input  wire logic [7:0]                        EVENT_STATUS,
  input  wire logic                              STB_BIT1,
  input  wire logic                              STB_BIT2,
  input  wire logic                              STB_BIT3,
  input  wire logic                              STB_BIT7,
  input  wire logic                              RQS_SENT,
  input  wire logic [sbsr_pkg::NUM_CHANNELS-1:0] CHAN_FAIL,
  input  wire logic                              TRIG_FAIL,
  input  wire logic                              TBASE_FAIL,
  output var  logic                              CMD_READY,
  output var  logic                              RSP_VALID,
  output var  logic [15:0]                       RSP_DATA,
  output var  logic                              SRQ,
  output var  logic [7:0]                        SERIAL_POLL,
  output var  logic                              CLS_PULSE
);
  import sbsr_pkg::*;

  // ==========================================================================
  // Reset release
  // Only the second stage is read; the first may still be settling after release.
  logic       rst_meta_ff, rst_sync_ff;
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // ==========================================================================
  // Status byte assembly
  logic [7:0] sre_ff, nxt_sre;
  logic [7:0] ese_ff, nxt_ese;
  logic [7:0] stb;
  logic       mss;
  logic       rqs_ff, nxt_rqs;

  // Bit 6 stays zero here; the summary is spliced in only where it is reported.
  always_comb begin
    stb                    = BYTE_ZERO;
    stb[STB_INPUT_BUF_BIT] = INPUT_BUFFER_SUMMARY;
    stb[STB_BIT1_POS]      = STB_BIT1;
    stb[STB_BIT2_POS]      = STB_BIT2;
    stb[STB_BIT3_POS]      = STB_BIT3;
    stb[STB_MSG_AVAIL_BIT] = MSG_AVAILABLE;
    stb[STB_EVENT_SUM_BIT] = |(EVENT_STATUS & ese_ff);
    stb[STB_BIT7_POS]      = STB_BIT7;
  end

  // Combinational so it follows either register in the same cycle.
  assign mss = sbsr_any_enabled(stb, sre_ff);

  // ==========================================================================
  // Command handling
  logic        st_start, st_busy, st_done;
  logic [15:0] st_result;
  logic        busy_ff, nxt_busy;
  logic        rsp_v_ff, nxt_rsp_v;
  logic [15:0] rsp_d_ff, nxt_rsp_d;
  logic        cls_ff, nxt_cls;
  logic        srq_ff, nxt_srq;
  logic [7:0]  poll_ff, nxt_poll;
  logic        ready_ff, nxt_ready;

  always_comb begin
    nxt_sre   = sre_ff;
    nxt_ese   = ese_ff;
    nxt_busy  = busy_ff;
    nxt_rsp_v = 1'b0;
    nxt_rsp_d = rsp_d_ff;
    nxt_cls   = 1'b0;
    st_start  = 1'b0;
    // Commands are only taken when the previous one is finished.
    // A command offered while busy is dropped with no answer; wait for ready.
    if (CMD_VALID && !busy_ff) begin
      unique case (CMD_CODE)
        SBSR_CMD_SRE_WR: nxt_sre = CMD_DATA & SRE_WRITE_MASK;
        SBSR_CMD_ESE_WR: nxt_ese = CMD_DATA;
        SBSR_CMD_SRE_RD: begin
          nxt_rsp_v = 1'b1;
          nxt_rsp_d = {BYTE_ZERO, sre_ff & SRE_WRITE_MASK};
        end
        SBSR_CMD_STB_RD: begin
          // A read only samples; nothing in the status byte is touched.
          nxt_rsp_v = 1'b1;
          nxt_rsp_d = {BYTE_ZERO, stb[STB_BIT7_POS], mss, stb[STB_EVENT_SUM_BIT:0]};
        end
        SBSR_CMD_TST: begin
          st_start = 1'b1;
          nxt_busy = 1'b1;
        end
        SBSR_CMD_CLS: begin
          // Event sources and the event register outside are cleared by this pulse.
          nxt_cls = 1'b1;
        end
        SBSR_CMD_WAI: ;
        SBSR_CMD_NONE: ;
      endcase
    end
    if (busy_ff && st_done) begin
      nxt_busy  = 1'b0;
      nxt_rsp_v = 1'b1;
      nxt_rsp_d = st_result;
    end
    // Ready falls at the edge that takes a self-test, so no second command slips in.
    nxt_ready = !nxt_busy && !(st_busy && !st_done);
  end

  // ==========================================================================
  // Service request
  // Request-service is set on a rising master summary and cleared by a poll or by a
  // falling summary, so one reason for service is reported to the controller once.
  // When the rise and the poll meet in one cycle the rise wins, so no request is lost.
  logic       mss_ff;
  logic       nxt_mss;

  always_comb begin
    nxt_mss = mss;
    nxt_rqs = rqs_ff;
    if (mss && !mss_ff) begin
      nxt_rqs = 1'b1;
    end else if (RQS_SENT || !mss) begin
      nxt_rqs = 1'b0;
    end
    nxt_srq  = mss && nxt_rqs;
    nxt_poll = {stb[STB_BIT7_POS], nxt_rqs, stb[STB_EVENT_SUM_BIT:0]};
  end

  always_ff @(posedge CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      mss_ff  <= 1'b0;
      rqs_ff  <= 1'b0;
      srq_ff  <= 1'b0;
      poll_ff <= BYTE_ZERO;
    end else begin
      mss_ff  <= nxt_mss;
      rqs_ff  <= nxt_rqs;
      srq_ff  <= nxt_srq;
      poll_ff <= nxt_poll;
    end
  end

  // ==========================================================================
  // Command state
  always_ff @(posedge CLK or negedge rst_sync_ff) begin
    if (!rst_sync_ff) begin
      sre_ff   <= SRE_RESET;
      ese_ff   <= ESE_RESET;
      busy_ff  <= 1'b0;
      ready_ff <= 1'b0;
      rsp_v_ff <= 1'b0;
      rsp_d_ff <= TST_PASS;
      cls_ff   <= 1'b0;
    end else begin
      sre_ff   <= nxt_sre;
      ese_ff   <= nxt_ese;
      busy_ff  <= nxt_busy;
      ready_ff <= nxt_ready;
      rsp_v_ff <= nxt_rsp_v;
      rsp_d_ff <= nxt_rsp_d;
      cls_ff   <= nxt_cls;
    end
  end

  sbsr_selftest u_selftest (
    .clk        (CLK),
    .rst_n      (rst_sync_ff),
    .start      (st_start),
    .chan_fail  (CHAN_FAIL),
    .trig_fail  (TRIG_FAIL),
    .tbase_fail (TBASE_FAIL),
    .busy       (st_busy),
    .done       (st_done),
    .result     (st_result)
  );

  // ==========================================================================
  // Outputs
  // Every output is a flop copy, so the controller never samples a decode glitch.
  assign CMD_READY   = ready_ff;
  assign RSP_VALID   = rsp_v_ff;
  assign RSP_DATA    = rsp_d_ff;
  assign SRQ         = srq_ff;
  assign SERIAL_POLL = poll_ff;
  assign CLS_PULSE   = cls_ff;
endmodule : sbsr_top
`default_nettype wire

// ### dv/sbsr_ctl_model.sv
// Controller model: serially polls the device while it requests service.
// Assumes the bench raises poll_en only when a poll is wanted.
`default_nettype none
module sbsr_ctl_model #(
  parameter int POLL_DELAY = 3
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic poll_en,
  input  wire logic srq,
  output var  logic rqs_sent
);
  timeunit 1ns;
  timeprecision 1ns;
  int wait_cnt;
  // A slow poll leaves the request standing for a while, as a real bus does.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rqs_sent <= 1'b0;
      wait_cnt <= 0;
    end else begin
      rqs_sent <= 1'b0;
      if (poll_en && srq && !rqs_sent && wait_cnt == POLL_DELAY) begin
        rqs_sent <= 1'b1;
        wait_cnt <= 0;
      end else if (poll_en && srq && !rqs_sent) begin
        wait_cnt <= wait_cnt + 1;
      end
    end
  end
endmodule : sbsr_ctl_model
`default_nettype wire

// ### dv/sbsr_monitor.sv
// Port checker for sbsr_top, bound to every instance.
// Assumes a command is taken when CMD_VALID and CMD_READY are both high.
`default_nettype none
module sbsr_monitor
  import sbsr_pkg::*;
(
  input wire logic                CLK,
  input wire logic                RESETN,
  input wire logic                CMD_VALID,
  input wire sbsr_pkg::sbsr_cmd_t CMD_CODE,
  input wire logic                CMD_READY,
  input wire logic                RQS_SENT,
  input wire logic                RSP_VALID,
  input wire logic [15:0]         RSP_DATA,
  input wire logic                SRQ,
  input wire logic [7:0]          SERIAL_POLL,
  input wire logic                CLS_PULSE
);
  timeunit 1ns;
  timeprecision 1ns;
  import sbsr_pkg::*;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);
  logic tk;
  assign tk = CMD_VALID && CMD_READY;
  // ==========================================================================
  // Commands
  AST_SRE_B6: assert property (tk && CMD_CODE == SBSR_CMD_SRE_RD |=>
    RSP_VALID && !RSP_DATA[6]) else $error("mask bit 6 read back set");
  AST_STB_HI: assert property (tk && CMD_CODE == SBSR_CMD_STB_RD |=>
    RSP_VALID && RSP_DATA[15:8] == 8'h00) else $error("bad status answer");
  AST_CLS: assert property (tk && CMD_CODE == SBSR_CMD_CLS |=>
    CLS_PULSE ##1 !CLS_PULSE) else $error("clear pulse missing");
  AST_CLS_SRC: assert property (CLS_PULSE |-> $past(tk) &&
    $past(CMD_CODE) == SBSR_CMD_CLS) else $error("stray clear pulse");
  AST_WAI: assert property (tk && CMD_CODE == SBSR_CMD_WAI |=>
    !RSP_VALID && !CLS_PULSE) else $error("wait command acted");
  AST_TST_BUSY: assert property (tk && CMD_CODE == SBSR_CMD_TST |=>
    !CMD_READY) else $error("ready during self-test");
  AST_TST_LEN: assert property (tk && CMD_CODE == SBSR_CMD_TST |=>
    !RSP_VALID [*8] ##[10:60] RSP_VALID) else $error("self-test length");
  // ==========================================================================
  // Service request
  AST_SRQ_RQS: assert property (SRQ |-> SERIAL_POLL[6])
    else $error("request without poll bit");
  AST_RQS_CLR: assert property (RQS_SENT |=> !SRQ)
    else $error("request kept after poll");
  cover property (tk && CMD_CODE == SBSR_CMD_TST);
  cover property (SRQ ##1 RQS_SENT);
  cover property (CLS_PULSE);
endmodule : sbsr_monitor
bind sbsr_top sbsr_monitor i_mon (.CLK(CLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID),
  .CMD_CODE(CMD_CODE), .CMD_READY(CMD_READY), .RQS_SENT(RQS_SENT), .RSP_VALID(RSP_VALID),
  .RSP_DATA(RSP_DATA), .SRQ(SRQ), .SERIAL_POLL(SERIAL_POLL), .CLS_PULSE(CLS_PULSE));
`default_nettype wire

// ### dv/sbsr_top_test.sv
// Self-checking bench for sbsr_top: command tasks and checked sequences.
// Assumes the controller model polls only while poll_en is high.
`default_nettype none
module sbsr_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import sbsr_pkg::*;
  logic        CLK = 1'b0;
  logic        RESETN = 1'b0;
  logic        vld = 1'b0;
  sbsr_cmd_t   code = SBSR_CMD_NONE;
  logic [7:0]  dat = 8'h00;
  logic [7:0]  st = 8'h00;
  logic [7:0]  ev = 8'h00;
  logic [3:0]  fl = 4'h0;
  logic        poll_en = 1'b0;
  logic        rqs_sent, rdy, rv, srq, clsp;
  logic [15:0] rd, got;
  logic [7:0]  sp;
  logic [7:0]  wv [4] = '{8'hFF, 8'h40, 8'h11, 8'h00};
  int          err_count = 0;
  int          comparisons = 0;
  int          i;
  always #50 CLK = ~CLK;
  sbsr_top i_dut (.CLK(CLK), .RESETN(RESETN), .CMD_VALID(vld), .CMD_CODE(code),
    .CMD_DATA(dat), .INPUT_BUFFER_SUMMARY(st[0]), .MSG_AVAILABLE(st[4]), .EVENT_STATUS(ev),
    .STB_BIT1(st[1]), .STB_BIT2(st[2]), .STB_BIT3(st[3]), .STB_BIT7(st[7]),
    .RQS_SENT(rqs_sent), .CHAN_FAIL(fl[1:0]), .TRIG_FAIL(fl[2]), .TBASE_FAIL(fl[3]),
    .CMD_READY(rdy), .RSP_VALID(rv), .RSP_DATA(rd), .SRQ(srq), .SERIAL_POLL(sp),
    .CLS_PULSE(clsp));
  sbsr_ctl_model i_ctl (.clk(CLK), .rst_n(RESETN), .poll_en(poll_en), .srq(srq),
    .rqs_sent(rqs_sent));
  // ==========================================================================
  // Tasks
  task automatic close_out;
    if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Waits at falling edges so registered outputs have settled.
  task automatic wait_for(input int sel);
    for (int n = 0; n < 100; n++) begin
      @(negedge CLK);
      if (sel == 0 && rdy === 1'b1 || sel == 1 && rv === 1'b1) return;
    end
    err_count++;
    close_out();
  endtask : wait_for
  task automatic cmd(input sbsr_cmd_t c, input logic [7:0] d);
    wait_for(0);
    @(posedge CLK);
    vld  <= 1'b1;
    code <= c;
    dat  <= d;
    @(posedge CLK);
    vld  <= 1'b0;
  endtask : cmd
  task automatic query(input sbsr_cmd_t c);
    cmd(c, 8'h00);
    wait_for(1);
    got = rd;
  endtask : query
  // ==========================================================================
  // Sequence
  initial begin
    repeat (12) @(posedge CLK);
    RESETN <= 1'b1;
    query(SBSR_CMD_SRE_RD);
    chk(got, 16'h0000);
    for (i = 0; i < 4; i++) begin
      cmd(SBSR_CMD_SRE_WR, wv[i]);
      query(SBSR_CMD_SRE_RD);
      chk(got, {8'h00, wv[i] & 8'hBF});
    end
    cmd(SBSR_CMD_ESE_WR, 8'h01);
    for (i = 0; i < 8; i++) begin
      if (i == 6) continue;
      @(posedge CLK);
      st <= (i == 5) ? 8'h00 : 8'h01 << i;
      ev <= (i == 5) ? 8'h01 : 8'h00;
      query(SBSR_CMD_STB_RD);
      chk(got, 16'h0001 << i);
      chk({8'h00, sp}, 16'h0001 << i);
      chk({15'h0000, srq}, 16'h0000);
    end
    @(posedge CLK);
    st <= 8'h01;
    ev <= 8'h00;
    cmd(SBSR_CMD_SRE_WR, 8'h10);
    query(SBSR_CMD_STB_RD);
    chk(got, 16'h0001);
    chk({15'h0000, srq}, 16'h0000);
    @(posedge CLK);
    st <= 8'h11;
    query(SBSR_CMD_STB_RD);
    chk(got, 16'h0051);
    chk({srq, sp}, 9'h151);
    query(SBSR_CMD_STB_RD);
    chk(got, 16'h0051);
    poll_en <= 1'b1;
    for (i = 0; i < 20 && srq !== 1'b0; i++) @(negedge CLK);
    chk({srq, sp}, 9'h011);
    repeat (8) @(negedge CLK);
    chk({srq, sp}, 9'h011);
    poll_en <= 1'b0;
    @(posedge CLK);
    st <= 8'h01;
    @(posedge CLK);
    st <= 8'h11;
    repeat (3) @(negedge CLK);
    chk({srq, sp}, 9'h151);
    query(SBSR_CMD_STB_RD);
    chk(got, 16'h0051);
    cmd(SBSR_CMD_CLS, 8'h00);
    @(negedge CLK);
    chk({15'h0000, clsp}, 16'h0001);
    cmd(SBSR_CMD_WAI, 8'h00);
    @(negedge CLK);
    chk({rv, clsp, rdy}, 3'h1);
    query(SBSR_CMD_SRE_RD);
    chk(got, 16'h0010);
    for (i = 0; i < 16; i++) begin
      @(posedge CLK);
      fl <= i[3:0];
      query(SBSR_CMD_TST);
      chk(got, {2'h0, fl[3:2], 2'h0, fl[1:0], 8'h00});
    end
    close_out();
  end
endmodule : sbsr_top_test
`default_nettype wire
